// ===== verilog/sfr_exec_cfg.svh
// Offsets, field positions, reset values and sizes of the execution block.
// Assumes inclusion by bare name from the execution block and the bench.
`ifndef SFR_EXEC_CFG_SVH
`define SFR_EXEC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CMD 12'h000
`define OFS_WREG 12'h004
`define OFS_STAT 12'h008
`define OFS_SPAGE 4'h1
`define OFS_FILE 3'h1

// ----------------------------------------
// Command word fields
// ----------------------------------------
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_DEST_BIT 3
`define CMD_ADDR_LSB 4
`define CMD_ADDR_MSB 10
`define CMD_IMM_LSB 11
`define CMD_IMM_MSB 18

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define STAT_ZERO_BIT 0
`define STAT_NIBBLE_BIT 1
`define STAT_CARRY_BIT 2
`define STAT_POWERDOWN_BIT 3
`define STAT_EXPIRY_BIT 4
`define STAT_HALT_BIT 5

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SPAGE_COUNT 22
`define FILE_COUNT 128
`define RST_WREG 8'h00
`define RST_EXPIRY 1'b1
`define RST_POWERDOWN 1'b1

`endif

// ===== verilog/sfr_exec_pkg.sv
// Types shared by the execution block and its subtractor.
// Assumes the constants header sits on the include path.
package sfr_exec_pkg;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_STORE_SPECIAL_PAGE = 3'h1,
		OP_LOAD_SPECIAL_PAGE = 3'h2,
		OP_SUB_FROM_FILE = 3'h3,
		OP_SUB_FROM_IMMEDIATE = 3'h4,
		OP_HALT = 3'h5
	} op_e;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] imm;
		logic [6:0] addr;
		logic dest;
		logic [2:0] op;
	} cmd_s;

	typedef struct packed {
		logic carry;
		logic nibbleBorrowFlag;
		logic zero;
	} flags_s;

endpackage : sfr_exec_pkg

// ===== verilog/sub_borrow_unit.sv
// Two's-complement subtractor with zero, nibble and carry flags.
// Assumes purely combinational use inside the execution block.
`timescale 1ns/100ps
module sub_borrow_unit
	import sfr_exec_pkg::*;
(
	// Operands
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	// Result
	output logic [7:0] difference,
	output flags_s flags
);

	logic [8:0] wide;
	logic [4:0] low;

	always_comb begin
		wide = {1'b0, minuend} - {1'b0, subtrahend};
		low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
		difference = wide[7:0];
		// Carry high means no borrow
		flags.carry = ~wide[8];
		flags.nibbleBorrowFlag = ~low[4];
		flags.zero = (wide[7:0] == 8'h00);
	end

endmodule : sub_borrow_unit

// ===== verilog/sfr_subtract_sleep_exec.sv
// Executes special-page moves, subtracts and halt entry from APB commands.
// Assumes an APB master on ref_clk and a watchdog that obeys watchdogClear.
//
// How it works
// - Store copies working register into special page
// - Load copies special page into working register
// - File subtract computes register minus working register
// - Destination bit picks working register or file
// - Immediate subtract updates zero, nibble, carry flags
// - Immediate subtract always writes working register
// - Halt clears watchdog counter and divider
// - Halt sets expiry bit, clears powerdown bit
// - Halt then stops instruction execution
// - Halt completes in one cycle
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "sfr_exec_cfg.svh"
module sfr_subtract_sleep_exec
	import sfr_exec_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side
	input wire logic wakeReq,
	output logic haltMode,
	output logic watchdogClear
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] wreg_q, wreg_d;
	flags_s flags_q, flags_d;
	logic expiry_q, expiry_d;
	logic powerdown_q, powerdown_d;
	logic halt_q, halt_d;
	logic wdClr_q, wdClr_d;
	logic [31:0] prdata_q, prdata_d;
	logic [7:0] fileMem [`FILE_COUNT];
	logic [7:0] spView [`SPAGE_COUNT];

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic setupPhase, accessPhase, wrAccess;
	logic isCmd, isWreg, isStat, isSpage, isFile, mapped;
	logic [4:0] apbSpIdx;
	logic [6:0] apbFileIdx;

	always_comb begin
		setupPhase = psel & ~penable;
		accessPhase = psel & penable;
		wrAccess = accessPhase & pwrite;
		apbSpIdx = paddr[6:2];
		apbFileIdx = paddr[8:2];
		isCmd = (paddr == `OFS_CMD);
		isWreg = (paddr == `OFS_WREG);
		isStat = (paddr == `OFS_STAT);
		isSpage = (paddr[11:8] == `OFS_SPAGE) && (paddr[7] == 1'b0)
			&& (paddr[1:0] == 2'b00) && (apbSpIdx < 5'(`SPAGE_COUNT));
		isFile = (paddr[11:9] == `OFS_FILE) && (paddr[1:0] == 2'b00);
		mapped = isCmd | isWreg | isStat | isSpage | isFile;
	end

	assign pready = accessPhase;
	assign pslverr = accessPhase & ~mapped;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	cmd_s cmd;
	op_e op;
	logic execValid, spOk;
	logic [4:0] spSel;

	always_comb begin
		cmd.op = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
		cmd.dest = pwdata[`CMD_DEST_BIT];
		cmd.addr = pwdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
		cmd.imm = pwdata[`CMD_IMM_MSB:`CMD_IMM_LSB];
		op = op_e'(cmd.op);
		spSel = cmd.addr[4:0];
		spOk = (cmd.addr < 7'(`SPAGE_COUNT));
		// Nothing executes while halted
		execValid = wrAccess & isCmd & ~halt_q;
	end

	// ----------------------------------------
	// Subtractor
	// ----------------------------------------
	logic [7:0] subA, subDiff;
	flags_s subFlags;

	always_comb begin
		subA = (op == OP_SUB_FROM_IMMEDIATE) ? cmd.imm : fileMem[cmd.addr];
	end

	sub_borrow_unit u_sub (
		.minuend(subA),
		.subtrahend(wreg_q),
		.difference(subDiff),
		.flags(subFlags)
	);

	// ----------------------------------------
	// Execution next state
	// ----------------------------------------
	logic fileWe, spWe;
	logic [6:0] fileIdx;
	logic [4:0] spIdx;
	logic [7:0] fileWdata, spWdata;

	always_comb begin
		wreg_d = wreg_q;
		flags_d = flags_q;
		expiry_d = expiry_q;
		powerdown_d = powerdown_q;
		halt_d = halt_q;
		wdClr_d = 1'b0;
		fileWe = 1'b0;
		fileIdx = apbFileIdx;
		fileWdata = pwdata[7:0];
		spWe = 1'b0;
		spIdx = apbSpIdx;
		spWdata = pwdata[7:0];
		if (halt_q && wakeReq) begin
			halt_d = 1'b0;
		end
		if (execValid) begin
			unique case (op)
				OP_NONE: begin
				end
				OP_STORE_SPECIAL_PAGE: begin
					spWe = spOk;
					spIdx = spSel;
					spWdata = wreg_q;
				end
				OP_LOAD_SPECIAL_PAGE: begin
					if (spOk) begin
						wreg_d = spView[spSel];
					end
				end
				OP_SUB_FROM_FILE: begin
					flags_d = subFlags;
					if (cmd.dest) begin
						fileWe = 1'b1;
						fileIdx = cmd.addr;
						fileWdata = subDiff;
					end else begin
						wreg_d = subDiff;
					end
				end
				OP_SUB_FROM_IMMEDIATE: begin
					flags_d = subFlags;
					wreg_d = subDiff;
				end
				OP_HALT: begin
					wdClr_d = 1'b1;
					expiry_d = 1'b1;
					powerdown_d = 1'b0;
					halt_d = 1'b1;
				end
				default: begin
				end
			endcase
		end else if (wrAccess) begin
			if (isWreg) begin
				wreg_d = pwdata[7:0];
			end
			if (isStat) begin
				flags_d.zero = pwdata[`STAT_ZERO_BIT];
				flags_d.nibbleBorrowFlag = pwdata[`STAT_NIBBLE_BIT];
				flags_d.carry = pwdata[`STAT_CARRY_BIT];
			end
			spWe = isSpage;
			fileWe = isFile;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wreg_q <= `RST_WREG;
			flags_q <= '0;
			expiry_q <= `RST_EXPIRY;
			powerdown_q <= `RST_POWERDOWN;
			halt_q <= 1'b0;
			wdClr_q <= 1'b0;
		end else begin
			wreg_q <= wreg_d;
			flags_q <= flags_d;
			expiry_q <= expiry_d;
			powerdown_q <= powerdown_d;
			halt_q <= halt_d;
			wdClr_q <= wdClr_d;
		end
	end

	assign haltMode = halt_q;
	assign watchdogClear = wdClr_q;

	// ----------------------------------------
	// Special-page registers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `SPAGE_COUNT; g++) begin : gSpage
			logic [7:0] entry_q, entry_d;
			always_comb begin
				entry_d = (spWe && spIdx == 5'(g)) ? spWdata : entry_q;
			end
			always_ff @(posedge ref_clk) begin
				if (!rst_b) begin
					entry_q <= 8'h00;
				end else begin
					entry_q <= entry_d;
				end
			end
			assign spView[g] = entry_q;
		end
	endgenerate

	// ----------------------------------------
	// File registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (fileWe) begin
			fileMem[fileIdx] <= fileWdata;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		prdata_d = prdata_q;
		if (setupPhase && !pwrite) begin
			prdata_d = 32'h0000_0000;
			if (isWreg) begin
				prdata_d[7:0] = wreg_q;
			end else if (isStat) begin
				prdata_d[`STAT_ZERO_BIT] = flags_q.zero;
				prdata_d[`STAT_NIBBLE_BIT] = flags_q.nibbleBorrowFlag;
				prdata_d[`STAT_CARRY_BIT] = flags_q.carry;
				prdata_d[`STAT_POWERDOWN_BIT] = powerdown_q;
				prdata_d[`STAT_EXPIRY_BIT] = expiry_q;
				prdata_d[`STAT_HALT_BIT] = halt_q;
			end else if (isSpage) begin
				prdata_d[7:0] = spView[apbSpIdx];
			end else if (isFile) begin
				prdata_d[7:0] = fileMem[apbFileIdx];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			prdata_q <= 32'h0000_0000;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_STORE_COPY: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_STORE_SPECIAL_PAGE && spOk
		|=> spView[$past(spSel)] == $past(wreg_q) && $stable(wreg_q))
		else $error("store did not copy working register");

	AST_LOAD_COPY: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_LOAD_SPECIAL_PAGE && spOk
		|=> wreg_q == $past(spView[spSel]))
		else $error("load did not fill working register");

	AST_SUBF_TO_WREG: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_SUB_FROM_FILE && !cmd.dest
		|=> wreg_q == 8'($past(fileMem[cmd.addr]) - $past(wreg_q)))
		else $error("file subtract result wrong");

	AST_SUBF_TO_FILE: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_SUB_FROM_FILE && cmd.dest
		|=> $stable(wreg_q) && fileMem[$past(cmd.addr)] == $past(subDiff))
		else $error("file subtract destination wrong");

	AST_SUBI_RESULT: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_SUB_FROM_IMMEDIATE
		|=> wreg_q == 8'($past(cmd.imm) - $past(wreg_q)))
		else $error("immediate subtract result wrong");

	AST_SUB_FLAGS: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && (op == OP_SUB_FROM_IMMEDIATE || op == OP_SUB_FROM_FILE)
		|=> flags_q.carry == ($past(subA) >= $past(wreg_q))
		&& flags_q.zero == ($past(subA) == $past(wreg_q)))
		else $error("subtract flags wrong");

	AST_NIBBLE_FLAG: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && (op == OP_SUB_FROM_IMMEDIATE || op == OP_SUB_FROM_FILE)
		|=> flags_q.nibbleBorrowFlag == ($past(subA[3:0]) >= $past(wreg_q[3:0])))
		else $error("nibble flag wrong");

	AST_HALT_WATCHDOG: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_HALT |=> watchdogClear ##1 !watchdogClear)
		else $error("watchdog clear pulse wrong");

	AST_HALT_STATUS: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_HALT
		|=> expiry_q && !powerdown_q && $stable(flags_q))
		else $error("halt status bits wrong");

	AST_HALT_HOLD: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		haltMode && !wakeReq && wrAccess && isCmd
		|=> haltMode && $stable(wreg_q) && $stable(flags_q))
		else $error("command ran while halted");

	AST_HALT_ONE_CYCLE: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && op == OP_HALT |-> pready ##1 (haltMode && watchdogClear))
		else $error("halt took more than one cycle");

	AST_SPAGE_FLAGS: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		execValid && (op == OP_LOAD_SPECIAL_PAGE || op == OP_STORE_SPECIAL_PAGE)
		|-> pready ##1 ($stable(flags_q) && $stable(expiry_q) && $stable(powerdown_q)))
		else $error("special-page move touched flags");

endmodule : sfr_subtract_sleep_exec

// ===== sim/sfr_subtract_sleep_exec_tb.sv
// Self-checking bench for the special-page, subtract and halt execution block.
// Assumes the design files and the constants header are on the include path.
`timescale 1ns/100ps
`include "sfr_exec_cfg.svh"
module sfr_subtract_sleep_exec_tb import sfr_exec_pkg::*;;

	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic wakeReq = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdv;
	logic pready;
	logic pslverr;
	logic haltMode;
	logic watchdogClear;
	logic ev;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;

	always #2 ref_clk = ~ref_clk;

	sfr_subtract_sleep_exec dut_u (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.wakeReq(wakeReq),
		.haltMode(haltMode),
		.watchdogClear(watchdogClear)
	);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic final_report();
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			err_total++;
			$display("ERROR %0t: got %h, expected %h", $time, g, x);
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Ends on the first edge that samples pready high
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(rdv, x);
	endtask : rdc

	function automatic logic [31:0] cmd(op_e op, logic dst, logic [6:0] a, logic [7:0] imm);
		return {13'h0000, imm, a, dst, op};
	endfunction : cmd

	// Carry, nibble and zero flags; high means no borrow
	function automatic logic [31:0] flg(logic [7:0] m, logic [7:0] s);
		return {29'h0, m >= s, m[3:0] >= s[3:0], m == s};
	endfunction : flg

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_special();
		wr(`OFS_STAT, 32'h05);
		wr(`OFS_WREG, 32'hAA);
		wr(`OFS_CMD, cmd(OP_STORE_SPECIAL_PAGE, 1'b0, 7'd21, 8'h00));
		rdc(12'h154, 32'hAA);
		wr(12'h10C, 32'h55);
		wr(`OFS_CMD, cmd(OP_LOAD_SPECIAL_PAGE, 1'b0, 7'd3, 8'h00));
		rdc(`OFS_WREG, 32'h55);
		wr(`OFS_CMD, cmd(OP_LOAD_SPECIAL_PAGE, 1'b0, 7'd22, 8'h00));
		rdc(`OFS_WREG, 32'h55);
		rdc(`OFS_STAT, 32'h1D);
	endtask : t_special

	task automatic t_file();
		wr(12'h3FC, 32'h06);
		wr(`OFS_WREG, 32'h05);
		wr(`OFS_CMD, cmd(OP_SUB_FROM_FILE, 1'b1, 7'd127, 8'h00));
		rdc(12'h3FC, 32'h01);
		rdc(`OFS_WREG, 32'h05);
		rdc(`OFS_STAT, 32'h1E);
		wr(12'h200, 32'h05);
		wr(`OFS_WREG, 32'h06);
		wr(`OFS_CMD, cmd(OP_SUB_FROM_FILE, 1'b0, 7'd0, 8'h00));
		rdc(`OFS_WREG, 32'hFF);
		rdc(12'h200, 32'h05);
		rdc(`OFS_STAT, 32'h18);
	endtask : t_file

	task automatic t_imm();
		logic [15:0] tab [4] = '{16'h0606, 16'h1001, 16'h0001, 16'hFF00};
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_WREG, {24'h0, tab[i][7:0]});
			wr(`OFS_CMD, cmd(OP_SUB_FROM_IMMEDIATE, i[0], 7'd0, tab[i][15:8]));
			rdc(`OFS_WREG, {24'h0, tab[i][15:8] - tab[i][7:0]});
			rdc(`OFS_STAT, 32'h18 | flg(tab[i][15:8], tab[i][7:0]));
		end
		rdc(12'h200, 32'h05);
	endtask : t_imm

	task automatic t_halt();
		int n;
		wr(`OFS_STAT, 32'h02);
		wr(`OFS_CMD, cmd(OP_HALT, 1'b0, 7'd0, 8'h00));
		#1;
		chk({31'h0, watchdogClear}, 32'h1);
		chk({31'h0, haltMode}, 32'h1);
		@(posedge ref_clk);
		#1;
		chk({31'h0, watchdogClear}, 32'h0);
		rdc(`OFS_STAT, 32'h32);
		wr(`OFS_CMD, cmd(OP_SUB_FROM_IMMEDIATE, 1'b0, 7'd0, 8'h55));
		rdc(`OFS_WREG, 32'hFF);
		chk({31'h0, haltMode}, 32'h1);
		@(posedge ref_clk);
		wakeReq <= 1'b1;
		@(posedge ref_clk);
		wakeReq <= 1'b0;
		n = 0;
		while (haltMode !== 1'b0 && n < 5) begin
			@(posedge ref_clk);
			n++;
		end
		chk({31'h0, haltMode}, 32'h0);
		rdc(`OFS_STAT, 32'h12);
		xfer(1'b0, 12'h00C, 32'h0);
		chk({31'h0, ev}, 32'h1);
		chk(rdv, 32'h0);
	endtask : t_halt

	task automatic t_reset();
		wr(`OFS_CMD, cmd(OP_HALT, 1'b0, 7'd0, 8'h00));
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk({31'h0, haltMode}, 32'h0);
		chk({31'h0, watchdogClear}, 32'h0);
		rdc(`OFS_STAT, 32'h18);
		rdc(`OFS_WREG, 32'h00);
		rdc(12'h154, 32'h00);
	endtask : t_reset

	// ----------------------------------------
	// Main sequence and timeout
	// ----------------------------------------
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(`OFS_STAT, 32'h18);
		rdc(`OFS_WREG, 32'h00);
		t_special();
		t_file();
		t_imm();
		t_halt();
		t_reset();
		final_report();
	end

endmodule : sfr_subtract_sleep_exec_tb
